// [src/telemetry_adc_sequencer.sv]
`timescale 1ns/1ps
`include "telemetry_adc_regs.svh"
// Functional notes
// - Global converter samples selected input, single/continuous
// - First result 3.6ms, then every 1.8ms
// - Set new-result flag on fresh result
// - Temperature code is (T+273.15)*4+2048
// - Port converter reports only in power-up/on
// - Source current code offset-binary around 2048
// - Return current code offset-binary, 100uV steps
// - Voltage codes offset-binary, gain in continuous only
// - Close return switch to ground
// - Switch opens on trip/overcurrent, recloses after delay
// - Forced negative fault holds port in overload
// - Return breaker trip forces non-disabled ports overload
// - Return transistor on when first port idles, off on return breaker trip
module telemetry_adc_sequencer
	import telemetry_adc_pkg::*;
#(
	parameter int FIRST_CYC   = `FIRST_RESULT_CYC,
	parameter int REFRESH_CYC = `REFRESH_CYC
) (
	input  wire logic                              ref_clk,
	input  wire logic                              sys_rst,
	input  wire logic                              gadc_enable,
	input  wire logic                              gadc_continuous,
	input  wire logic                              gadc_start,
	input  wire logic                              gadc_high_gain,
	input  wire logic [2:0]                        gadc_sel,
	input  wire logic [2:0]                        gadc_port_sel,
	input  wire logic                              gadc_read_ack,
	input  wire logic [`ADC_WIDTH-1:0]             conv_sample,
	input  wire logic [`NUM_PORTS*`ADC_WIDTH-1:0]  port_conv_sample,
	input  wire logic [`NUM_PORTS*3-1:0]           port_state,
	input  wire logic                              return_breaker_trip,
	input  wire logic                              overcurrent_fault,
	input  wire logic [`NUM_PORTS-1:0]             neg_voltage_fault,
	input  wire logic                              restart_done,
	output logic [`ADC_WIDTH-1:0]                  gadc_result,
	output logic                                   gadc_new,
	output logic                                   gadc_busy,
	output logic [2:0]                             conv_mux_sel,
	output logic [2:0]                             conv_port_sel,
	output logic                                   conv_high_gain,
	output logic [`NUM_PORTS*`ADC_WIDTH-1:0]       port_source_current,
	output logic [`NUM_PORTS-1:0]                  port_result_valid,
	output logic [`NUM_PORTS-1:0]                  force_overload,
	output logic                                   sleep_return_switch_on,
	output logic                                   return_fet_on
);
	gadc_state_t  state_reg;       // Global converter state
	logic [31:0]  gcnt_reg;        // Global conversion timer
	logic [31:0]  pcnt_reg;        // Port refresh timer
	logic         start_pend_reg;  // Single-shot request waiting
	logic         prev_en_reg;     // Enable seen last cycle
	logic         gdone;           // A global result is due this cycle
	logic         pdone;           // Port results due this cycle
	logic         fault_reg;       // Return fault latched until restart
	logic         any_idle;        // Some port has reached idle or beyond

	assign gdone = (state_reg != GADC_IDLE) && (gcnt_reg == 32'h0);
	assign pdone = (pcnt_reg == 32'h0);
	assign gadc_busy = (state_reg != GADC_IDLE);

	// Input selection steers the analog mux; gain only in continuous mode
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			conv_mux_sel   <= `SEL_TEMP;
			conv_port_sel  <= 3'h0;
			conv_high_gain <= 1'b0;
		end else begin
			conv_mux_sel   <= gadc_sel;
			conv_port_sel  <= gadc_port_sel;
			conv_high_gain <= gadc_high_gain && gadc_continuous;
		end
	end

	// Latch single-shot requests until the sequencer accepts them
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			start_pend_reg <= 1'b0;
			prev_en_reg    <= 1'b0;
		end else begin
			prev_en_reg <= gadc_enable;
			if (gadc_start || (gadc_enable && !prev_en_reg)) begin
				start_pend_reg <= 1'b1;
			end else if (state_reg == GADC_IDLE) begin
				start_pend_reg <= 1'b0;
			end
		end
	end

	// Global conversion sequencer
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= GADC_IDLE;
			gcnt_reg  <= 32'h0;
		end else if (!gadc_enable) begin
			state_reg <= GADC_IDLE;
			gcnt_reg  <= 32'h0;
		end else begin
			case (state_reg)
				// Wait for a request or continuous operation
				GADC_IDLE: begin
					if (gadc_continuous || start_pend_reg) begin
						state_reg <= GADC_FIRST;
						gcnt_reg  <= 32'(FIRST_CYC - 1);
					end
				end
				// First result after the long settling time
				GADC_FIRST: begin
					if (gdone) begin
						if (gadc_continuous) begin
							state_reg <= GADC_RUN;
							gcnt_reg  <= 32'(REFRESH_CYC - 1);
						end else begin
							state_reg <= GADC_IDLE;
						end
					end else begin
						gcnt_reg <= gcnt_reg - 32'h1;
					end
				end
				// Continuous refresh
				GADC_RUN: begin
					if (!gadc_continuous && gdone) begin
						state_reg <= GADC_IDLE;
					end else if (gdone) begin
						gcnt_reg <= 32'(REFRESH_CYC - 1);
					end else begin
						gcnt_reg <= gcnt_reg - 32'h1;
					end
				end
				default: begin
					state_reg <= GADC_IDLE;
				end
			endcase
		end
	end

	// Result capture; code formats are produced offset-binary by the converter
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			gadc_result <= `ADC_MID_CODE;
		end else if (gdone) begin
			gadc_result <= conv_sample;
		end
	end

	// New-result flag; a fresh result beats a simultaneous read
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			gadc_new <= 1'b0;
		end else if (gdone) begin
			gadc_new <= 1'b1;
		end else if (gadc_read_ack) begin
			gadc_new <= 1'b0;
		end
	end

	// Free-running port refresh timer
	always_ff @(posedge ref_clk) begin
		if (sys_rst || pdone) begin
			pcnt_reg <= 32'(REFRESH_CYC - 1);
		end else begin
			pcnt_reg <= pcnt_reg - 32'h1;
		end
	end

	// Per-port source current readback
	genvar p;
	generate
		for (p = 0; p < `NUM_PORTS; p++) begin : g_port
			logic powered; // Port in power-up or powered state
			assign powered = (port_state[p*3 +: 3] == 3'(PORT_POWER_UP)) ||
				(port_state[p*3 +: 3] == 3'(PORT_POWER_ON));
			// Refresh only while powered
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					port_source_current[p*`ADC_WIDTH +: `ADC_WIDTH] <= `ADC_MID_CODE;
					port_result_valid[p] <= 1'b0;
				end else if (!powered) begin
					port_result_valid[p] <= 1'b0;
				end else if (pdone) begin
					port_source_current[p*`ADC_WIDTH +: `ADC_WIDTH] <=
						port_conv_sample[p*`ADC_WIDTH +: `ADC_WIDTH];
					port_result_valid[p] <= 1'b1;
				end
			end
			// Overload forcing from return-side faults
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					force_overload[p] <= 1'b0;
				end else begin
					force_overload[p] <= neg_voltage_fault[p] ||
						(return_breaker_trip &&
						port_state[p*3 +: 3] != 3'(PORT_DISABLED));
				end
			end
		end
	endgenerate

	// Return fault latch: held open until the restart delay expires
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			fault_reg <= 1'b0;
		end else if (return_breaker_trip || overcurrent_fault) begin
			fault_reg <= 1'b1;
		end else if (restart_done) begin
			fault_reg <= 1'b0;
		end
	end

	// Deep-sleep return switch to ground
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sleep_return_switch_on <= 1'b1;
		end else begin
			sleep_return_switch_on <= !fault_reg &&
				!return_breaker_trip && !overcurrent_fault;
		end
	end

	// Any port out of disabled (idle or later) turns the return transistor on unless the return breaker has tripped
	always_comb begin
		any_idle = 1'b0;
		for (int i = 0; i < `NUM_PORTS; i++) begin
			if (port_state[i*3 +: 3] != 3'(PORT_DISABLED)) begin
				any_idle = 1'b1;
			end
		end
	end

	// Return-side transistor drive
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			return_fet_on <= 1'b0;
		end else begin
			return_fet_on <= any_idle && !return_breaker_trip;
		end
	end
endmodule

// [src/telemetry_adc_regs.svh]
`ifndef TELEMETRY_ADC_REGS_SVH
`define TELEMETRY_ADC_REGS_SVH

// Clock rate in kHz (40 MHz)
`define REF_CLK_KHZ 40000
// First result latency in microseconds
`define FIRST_RESULT_US 3600
// Refresh period in microseconds
`define REFRESH_US 1800
// Latency and refresh period in ref_clk cycles
`define FIRST_RESULT_CYC ((`FIRST_RESULT_US * `REF_CLK_KHZ) / 1000)
`define REFRESH_CYC ((`REFRESH_US * `REF_CLK_KHZ) / 1000)
// Mid-scale code of every offset-binary result
`define ADC_MID_CODE 12'h800
// Result width
`define ADC_WIDTH 12
// Number of ports
`define NUM_PORTS 5
// Input select encodings
`define SEL_TEMP 3'h0
`define SEL_RETURN_I 3'h1
`define SEL_SUPPLY_V 3'h2
`define SEL_PORT_V 3'h3

`endif

// [src/telemetry_adc_pkg.sv]
package telemetry_adc_pkg;
	// Global converter sequencing states
	typedef enum logic [1:0] {
		GADC_IDLE,
		GADC_FIRST,
		GADC_RUN
	} gadc_state_t;
	// Port power state as seen by telemetry and protection
	typedef enum logic [2:0] {
		PORT_DISABLED,
		PORT_IDLE,
		PORT_POWER_UP,
		PORT_POWER_ON,
		PORT_OVERLOAD,
		PORT_OTHER
	} port_state_t;
endpackage

// [testbench/telemetry_adc_sequencer_monitor.sv]
`timescale 1ns/1ps
`include "telemetry_adc_regs.svh"
module telemetry_adc_sequencer_monitor #(
	parameter int FIRST_CYC   = 20,
	parameter int REFRESH_CYC = 10
) (
	input wire logic                     ref_clk,
	input wire logic                     sys_rst,
	input wire logic                     gadc_enable,
	input wire logic                     gadc_continuous,
	input wire logic [`ADC_WIDTH-1:0]    gadc_result,
	input wire logic                     gadc_new,
	input wire logic                     gadc_busy,
	input wire logic                     conv_high_gain,
	input wire logic                     return_breaker_trip,
	input wire logic                     overcurrent_fault,
	input wire logic                     restart_done,
	input wire logic [`NUM_PORTS-1:0]    neg_voltage_fault,
	input wire logic [`NUM_PORTS*3-1:0]  port_state,
	input wire logic [`NUM_PORTS-1:0]    force_overload,
	input wire logic                     sleep_return_switch_on,
	input wire logic                     return_fet_on
);
	// One clock domain; everything is quiet while reset is held
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	chk_result_new_flag: assert property (
		$changed(gadc_result) |-> gadc_new) else $error("result moved without new flag");
	chk_no_early_result: assert property (
		$rose(gadc_enable) && !gadc_new |=> !gadc_new [*8]) else $error("result too early");
	chk_busy_on_start: assert property (
		$rose(gadc_enable) |-> ##[1:3] gadc_busy) else $error("sequencer never started");
	chk_gain_mode: assert property (
		conv_high_gain |-> $past(gadc_continuous)) else $error("high gain outside continuous");
	chk_switch_opens: assert property (
		return_breaker_trip || overcurrent_fault |=> !sleep_return_switch_on)
		else $error("return switch stayed closed on fault");
	chk_switch_recloses: assert property (
		$rose(sleep_return_switch_on) |-> $past(restart_done) || $past(restart_done, 2))
		else $error("return switch closed without restart delay");
	chk_neg_fault_hold: assert property (
		##1 (force_overload & $past(neg_voltage_fault)) == $past(neg_voltage_fault))
		else $error("negative fault port not in overload");
	chk_trip_overload: assert property (
		return_breaker_trip && port_state[2:0] != 3'h0 |=> force_overload[0])
		else $error("trip did not force overload");
	chk_fet_on_idle: assert property (
		port_state[2:0] == 3'h1 && !return_breaker_trip |=> return_fet_on)
		else $error("return transistor off with idle port");
	// Main scenarios reached
	cover property ($rose(gadc_new) && gadc_continuous);
	cover property ($rose(gadc_new) && !gadc_continuous);
	cover property ($fell(sleep_return_switch_on));
endmodule

// [testbench/telemetry_adc_sequencer_tb.sv]
`timescale 1ns/1ps
`include "telemetry_adc_regs.svh"
module telemetry_adc_sequencer_tb;
	import telemetry_adc_pkg::*;
	localparam int FIRST = 20;
	localparam int REFR  = 10;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        gadc_enable, gadc_continuous, gadc_start, gadc_high_gain, gadc_read_ack;
	logic        return_breaker_trip, overcurrent_fault, restart_done;
	logic [2:0]  gadc_sel, gadc_port_sel, conv_mux_sel, conv_port_sel;
	logic [11:0] conv_sample, gadc_result;
	logic [59:0] port_conv_sample, port_source_current;
	logic [14:0] port_state;
	logic [4:0]  neg_voltage_fault, port_result_valid, force_overload;
	logic        gadc_new, gadc_busy, conv_high_gain, sleep_return_switch_on, return_fet_on;
	int          failures = 0;
	int          checked = 0;
	int          n;
	// Clock generator
	always #12.5 ref_clk = ~ref_clk;
	telemetry_adc_sequencer #(.FIRST_CYC(FIRST), .REFRESH_CYC(REFR)) u_telemetry_adc_sequencer (
		.ref_clk, .sys_rst, .gadc_enable, .gadc_continuous, .gadc_start, .gadc_high_gain,
		.gadc_sel, .gadc_port_sel, .gadc_read_ack, .conv_sample, .port_conv_sample,
		.port_state, .return_breaker_trip, .overcurrent_fault, .neg_voltage_fault,
		.restart_done, .gadc_result, .gadc_new, .gadc_busy, .conv_mux_sel, .conv_port_sel,
		.conv_high_gain, .port_source_current, .port_result_valid, .force_overload,
		.sleep_return_switch_on, .return_fet_on);
	// Compare a value and count it
	task cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Step clocks, then let outputs settle
	task cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	// Wait for a fresh result under a bound, counting cycles
	task wait_new(input int lim);
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (gadc_new !== 1'b1 && n < lim);
	endtask
	// Acknowledge the result and change the sampled code
	task ack(input logic [11:0] v);
		@(posedge ref_clk);
		gadc_read_ack <= 1'b1;
		conv_sample <= v;
		@(posedge ref_clk);
		gadc_read_ack <= 1'b0;
	endtask
	// One conversion run on one input, single-shot or continuous
	task conv(input logic [2:0] s, input logic c);
		@(posedge ref_clk);
		gadc_sel <= s;
		gadc_port_sel <= s + 3'h1;
		gadc_continuous <= c;
		gadc_high_gain <= s[1];
		conv_sample <= {4'hA, 5'h0, s};
		gadc_enable <= 1'b1;
		wait_new(FIRST + 8);
		cmp("latency", 12'h1, 12'((n >= FIRST + 1) && (n <= FIRST + 4)));
		cmp("result", {4'hA, 5'h0, s}, gadc_result);
		cmp("mux sel", {9'h0, s}, {9'h0, conv_mux_sel});
		cmp("port sel", {9'h0, s + 3'h1}, {9'h0, conv_port_sel});
		cmp("gain", {11'h0, c & s[1]}, {11'h0, conv_high_gain});
		ack({4'h5, 5'h1F, ~s});
		if (c) begin
			wait_new(REFR + 6);
			cmp("refresh", 12'h1, 12'((n >= REFR - 4) && (n <= REFR + 2)));
			cmp("next result", {4'h5, 5'h1F, ~s}, gadc_result);
		end else begin
			cyc(3 * REFR);
			cmp("single stop", 12'h0, {10'h0, gadc_new, gadc_busy});
			@(posedge ref_clk);
			gadc_start <= 1'b1;
			@(posedge ref_clk);
			gadc_start <= 1'b0;
			wait_new(FIRST + 8);
			cmp("restart", {4'h5, 5'h1F, ~s}, gadc_result);
		end
		@(posedge ref_clk);
		gadc_enable <= 1'b0;
		// Clear the sticky flag so the next run measures its own latency
		ack(12'h000);
		cyc(4);
	endtask
	// Report and end the run
	task wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		{gadc_enable, gadc_continuous, gadc_start, gadc_high_gain, gadc_read_ack} = '0;
		{return_breaker_trip, overcurrent_fault, restart_done} = '0;
		{gadc_sel, gadc_port_sel, conv_sample, port_conv_sample} = '0;
		{port_state, neg_voltage_fault} = '0;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		cyc(2);
		cmp("reset result", `ADC_MID_CODE, gadc_result);
		cmp("reset switch", 12'h1, {11'h0, sleep_return_switch_on});
		for (int s = 0; s < 4; s++) conv(s[2:0], s[0]);
		@(posedge ref_clk);
		port_state <= {3'h0, 3'h0, 3'h3, 3'h0, 3'h1};
		port_conv_sample[35:24] <= 12'h9AB;
		cyc(2 * REFR + 4);
		cmp("port current", 12'h9AB, port_source_current[35:24]);
		cmp("port valid", 12'h004, {7'h0, port_result_valid});
		cmp("return fet", 12'h1, {11'h0, return_fet_on});
		@(posedge ref_clk);
		neg_voltage_fault <= 5'b00100;
		cyc(3);
		cmp("neg overload", 12'h004, {7'h0, force_overload});
		@(posedge ref_clk);
		neg_voltage_fault <= 5'b00000;
		return_breaker_trip <= 1'b1;
		cyc(3);
		cmp("trip overload", 12'h005, {7'h0, force_overload});
		cmp("switch open", 12'h0, {11'h0, sleep_return_switch_on});
		cmp("fet tripped", 12'h0, {11'h0, return_fet_on});
		@(posedge ref_clk);
		return_breaker_trip <= 1'b0;
		cyc(3);
		cmp("switch held", 12'h0, {11'h0, sleep_return_switch_on});
		@(posedge ref_clk);
		restart_done <= 1'b1;
		@(posedge ref_clk);
		restart_done <= 1'b0;
		cyc(3);
		cmp("switch closed", 12'h1, {11'h0, sleep_return_switch_on});
		@(posedge ref_clk);
		overcurrent_fault <= 1'b1;
		cyc(3);
		cmp("oc open", 12'h0, {11'h0, sleep_return_switch_on});
		wrap_up;
	end
	// Hang guard
	initial begin
		cyc(4000);
		failures++;
		wrap_up;
	end
endmodule
bind telemetry_adc_sequencer telemetry_adc_sequencer_monitor #(.FIRST_CYC(FIRST_CYC),
	.REFRESH_CYC(REFRESH_CYC)) u_mon (.ref_clk, .sys_rst, .gadc_enable, .gadc_continuous,
	.gadc_result, .gadc_new, .gadc_busy, .conv_high_gain, .return_breaker_trip,
	.overcurrent_fault, .restart_done, .neg_voltage_fault, .port_state, .force_overload,
	.sleep_return_switch_on, .return_fet_on);
